/* pkg/owg_pkg.sv */
package owg_pkg;
    localparam int NREG = 19;
    // register byte offsets
    localparam logic [7:0] OFF_VID_A_W  = 8'h00;
    localparam logic [7:0] OFF_VID_A_H  = 8'h04;
    localparam logic [7:0] OFF_VID_B_X  = 8'h08;
    localparam logic [7:0] OFF_VID_B_Y  = 8'h0C;
    localparam logic [7:0] OFF_VID_B_W  = 8'h10;
    localparam logic [7:0] OFF_VID_B_H  = 8'h14;
    localparam logic [7:0] OFF_BMP_A_X  = 8'h18;
    localparam logic [7:0] OFF_BMP_A_Y  = 8'h1C;
    localparam logic [7:0] OFF_BMP_A_W  = 8'h20;
    localparam logic [7:0] OFF_BMP_A_H  = 8'h24;
    localparam logic [7:0] OFF_BMP_B_X  = 8'h28;
    localparam logic [7:0] OFF_BMP_B_Y  = 8'h2C;
    localparam logic [7:0] OFF_BMP_B_W  = 8'h30;
    localparam logic [7:0] OFF_BMP_B_H  = 8'h34;
    localparam logic [7:0] OFF_CUR_X    = 8'h38;
    localparam logic [7:0] OFF_CUR_Y    = 8'h3C;
    localparam logic [7:0] OFF_REF_X    = 8'h40;
    localparam logic [7:0] OFF_REF_Y    = 8'h44;
    localparam logic [7:0] OFF_CTRL     = 8'h48;
    // field widths per register index (11 for x/size, 10 for y-start, 10 and 9 for ref x/y, 1 for ctrl)
    localparam logic [NREG*4-1:0] FIELD_W = {
        4'd1, 4'd9, 4'd10,
        4'd10, 4'd11,
        4'd11, 4'd11, 4'd10, 4'd11,
        4'd11, 4'd11, 4'd10, 4'd11,
        4'd11, 4'd11, 4'd10, 4'd11,
        4'd11, 4'd11};
    localparam logic [10:0] RESET_VAL   = 11'h000;
    localparam logic [10:0] REF_X_MIN_PRE  = 11'd20;
    localparam logic [10:0] REF_X_MIN_POST = 11'd22;
    localparam logic [10:0] REF_Y_MIN      = 11'd1;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    // one window's geometry in display coordinates
    typedef struct packed {
        logic [11:0] x0;
        logic [11:0] y0;
        logic [11:0] w;
        logic [11:0] h;
    } owg_win_s;

    typedef enum logic [1:0] {
        OWG_IDLE = 2'b00,
        OWG_RESP = 2'b01
    } owg_bus_e;
endpackage : owg_pkg

/* core/owg_regs.sv */
`timescale 1ns/1ps
module owg_regs
    import owg_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address, data and response
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // display timing
    input  wire logic        vertical_sync_strobe,
    input  wire logic [11:0] pix_x,
    input  wire logic [11:0] pix_y,
    // geometry in use and window hits
    output owg_win_s         vid_a_win,
    output owg_win_s         vid_b_win,
    output owg_win_s         bmp_a_win,
    output owg_win_s         bmp_b_win,
    output logic [11:0]      cursor_x0,
    output logic [11:0]      cursor_y0,
    output logic [3:0]       win_hit
);
    // pending (software) and active (display) copies
    logic [10:0] pend_reg [NREG];
    logic [10:0] act_reg  [NREG];
    logic [10:0] act_next [NREG];
    owg_win_s    vid_a_next;
    owg_win_s    vid_b_next;
    owg_win_s    bmp_a_next;
    owg_win_s    bmp_b_next;
    logic [11:0] cur_x_next;
    logic [11:0] cur_y_next;
    logic [3:0]  hit_next;

    owg_bus_e    wr_st_reg;
    owg_bus_e    rd_st_reg;
    logic [7:0]  aw_reg;
    logic        aw_have_reg;
    logic [31:0] wd_reg;
    logic [3:0]  ws_reg;
    logic        w_have_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic [1:0]  bresp_reg;

    // field mask for a register index
    function automatic logic [10:0] fmask(input int idx);
        logic [3:0] w;
        w = FIELD_W[idx*4 +: 4];
        fmask = 11'((12'h001 << w) - 12'h001);
    endfunction : fmask

    // decode a byte address to a register index, NREG when unmapped
    function automatic int dec(input logic [7:0] a);
        dec = NREG;
        if (a[1:0] == 2'b00 && a[7:2] < 6'(NREG))
            dec = int'(a[7:2]);
    endfunction : dec

    // zero-extended active field
    function automatic logic [11:0] ax(input int idx);
        ax = {1'b0, act_reg[idx]};
    endfunction : ax

    // coverage test of one axis
    function automatic logic inside_span(input logic [11:0] p,
                                         input logic [11:0] s,
                                         input logic [11:0] n);
        logic [12:0] e;
        e = {1'b0, s} + {1'b0, n};
        inside_span = ({1'b0, p} >= {1'b0, s}) && ({1'b0, p} < e);
    endfunction : inside_span

    // write channel: take address and data in either order
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire wr_go   = (wr_st_reg == OWG_IDLE)
                   && (aw_have_reg || aw_take) && (w_have_reg || w_take);
    wire [7:0]  wr_addr = aw_have_reg ? aw_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_have_reg ? wd_reg : s_axi_wdata;
    wire [3:0]  wr_strb = w_have_reg ? ws_reg : s_axi_wstrb;
    // the index fits five bits; unmapped addresses decode to NREG itself
    wire [4:0]  wr_idx  = 5'(dec(wr_addr));
    wire        wr_ok   = wr_idx < 5'(NREG);
    // bits of the field that the byte strobes let through
    wire [10:0] wr_bits = {{3{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [15:0] wr_lo   = {wr_strb[1] ? wr_data[15:8] : 8'h00,
                           wr_strb[0] ? wr_data[7:0] : 8'h00};

    assign s_axi_awready = (wr_st_reg == OWG_IDLE) && !aw_have_reg;
    assign s_axi_wready  = (wr_st_reg == OWG_IDLE) && !w_have_reg;
    assign s_axi_bvalid  = (wr_st_reg == OWG_RESP);
    assign s_axi_bresp   = bresp_reg;

    // read channel: one outstanding read
    wire        ar_take = s_axi_arvalid && s_axi_arready;
    wire [4:0]  rd_idx  = 5'(dec(s_axi_araddr));
    assign s_axi_arready = (rd_st_reg == OWG_IDLE);
    assign s_axi_rvalid  = (rd_st_reg == OWG_RESP);
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // bus handshake state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_st_reg   <= OWG_IDLE;
            rd_st_reg   <= OWG_IDLE;
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            aw_reg      <= 8'h00;
            wd_reg      <= 32'h0000_0000;
            ws_reg      <= 4'h0;
            bresp_reg   <= RESP_OKAY;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= RESP_OKAY;
        end
        else
        begin
            if (wr_go)
            begin
                wr_st_reg   <= OWG_RESP;
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
                bresp_reg   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else
            begin
                if (aw_take)
                begin
                    aw_have_reg <= 1'b1;
                    aw_reg      <= s_axi_awaddr;
                end
                if (w_take)
                begin
                    w_have_reg <= 1'b1;
                    wd_reg     <= s_axi_wdata;
                    ws_reg     <= s_axi_wstrb;
                end
                if (wr_st_reg == OWG_RESP && s_axi_bready)
                    wr_st_reg <= OWG_IDLE;
            end
            if (ar_take)
            begin
                rd_st_reg <= OWG_RESP;
                // read back the written copy, reserved bits as zero
                rdata_reg <= (rd_idx < NREG) ? {21'h000000, pend_reg[rd_idx]}
                                             : 32'h0000_0000;
                rresp_reg <= (rd_idx < NREG) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rd_st_reg == OWG_RESP && s_axi_rready)
                rd_st_reg <= OWG_IDLE;
        end
    end

    // software copy; bits above the field are dropped so slips stay harmless
    always_ff @(posedge aclk)
    begin
        for (int i = 0; i < NREG; i++)
        begin
            if (!aresetn)
                pend_reg[i] <= RESET_VAL;
            else if (wr_go && wr_idx == i)
                pend_reg[i] <= (pend_reg[i] & ~wr_bits)
                               | (wr_lo[10:0] & wr_bits & fmask(i));
        end
    end

    // shadow copy loads only at vertical sync
    always_comb
    begin
        for (int i = 0; i < NREG; i++)
            act_next[i] = vertical_sync_strobe ? pend_reg[i] : act_reg[i];
    end

    always_ff @(posedge aclk)
    begin
        for (int i = 0; i < NREG; i++)
            act_reg[i] <= aresetn ? act_next[i] : RESET_VAL;
    end

    // references in use, clamped to their minimums
    wire        filt_post = act_reg[18][0];
    wire [10:0] ref_x_min = filt_post ? REF_X_MIN_POST : REF_X_MIN_PRE;
    wire [11:0] display_ref_x = {1'b0, (act_reg[16] > ref_x_min) ? act_reg[16]
                                                                  : ref_x_min};
    wire [11:0] display_ref_y = {1'b0, (act_reg[17] > REF_Y_MIN) ? act_reg[17]
                                                                  : REF_Y_MIN};

    // window geometry in display coordinates; video A starts at the reference
    always_comb
    begin
        vid_a_next = '{display_ref_x, display_ref_y, ax(0), ax(1)};
        vid_b_next = '{12'(display_ref_x + ax(2)), 12'(display_ref_y + ax(3)),
                       ax(4), ax(5)};
        bmp_a_next = '{12'(display_ref_x + ax(6)), 12'(display_ref_y + ax(7)),
                       ax(8), ax(9)};
        bmp_b_next = '{12'(display_ref_x + ax(10)), 12'(display_ref_y + ax(11)),
                       ax(12), ax(13)};
        cur_x_next = 12'(display_ref_x + ax(14));
        cur_y_next = 12'(display_ref_y + ax(15));
        hit_next[0] = inside_span(pix_x, vid_a_next.x0, vid_a_next.w)
                      && inside_span(pix_y, vid_a_next.y0, vid_a_next.h);
        hit_next[1] = inside_span(pix_x, vid_b_next.x0, vid_b_next.w)
                      && inside_span(pix_y, vid_b_next.y0, vid_b_next.h);
        hit_next[2] = inside_span(pix_x, bmp_a_next.x0, bmp_a_next.w)
                      && inside_span(pix_y, bmp_a_next.y0, bmp_a_next.h);
        hit_next[3] = inside_span(pix_x, bmp_b_next.x0, bmp_b_next.w)
                      && inside_span(pix_y, bmp_b_next.y0, bmp_b_next.h);
    end

    // registered geometry outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            vid_a_win <= '0;
            vid_b_win <= '0;
            bmp_a_win <= '0;
            bmp_b_win <= '0;
            cursor_x0 <= 12'h000;
            cursor_y0 <= 12'h000;
            win_hit   <= 4'h0;
        end
        else
        begin
            vid_a_win <= vid_a_next;
            vid_b_win <= vid_b_next;
            bmp_a_win <= bmp_a_next;
            bmp_b_win <= bmp_b_next;
            cursor_x0 <= cur_x_next;
            cursor_y0 <= cur_y_next;
            win_hit   <= hit_next;
        end
    end
endmodule : owg_regs

/* tb/owg_regs_asserts.sv */
`timescale 1ns/1ps
module owg_regs_asserts
    import owg_pkg::*;
(
    // bus handshakes and display timing
    input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready, vertical_sync_strobe,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // geometry in use
    input wire logic [11:0] pix_x, pix_y, cursor_x0, cursor_y0,
    input wire owg_win_s    vid_a_win, vid_b_win, bmp_a_win,
    input wire logic [3:0]  win_hit
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // far edges of bitmap window a; 13 bits so a large size cannot wrap
    wire logic [12:0] bx_end = bmp_a_win.x0 + bmp_a_win.w;
    wire logic [12:0] by_end = bmp_a_win.y0 + bmp_a_win.h;
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_bready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready && s_axi_rready;
    endsequence
    wr_resp_a: assert property (wr_taken |=> s_axi_bvalid ##1 !s_axi_bvalid)
        else $error("write response not a single beat");
    wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    rd_resp_a: assert property (rd_taken |=> s_axi_rvalid ##1 !s_axi_rvalid)
        else $error("read response not a single beat");
    rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    unmapped_a: assert property (rd_taken ##0 s_axi_araddr > OFF_CTRL
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    shadow_a: assert property (
        // the edge after reset release loads the clamped reference once
        $changed({vid_a_win, vid_b_win, bmp_a_win, cursor_x0, cursor_y0})
        |-> $past(vertical_sync_strobe, 2) || !$past(aresetn, 2))
        else $error("geometry changed without vertical sync");
    ref_min_a: assert property ($past(vertical_sync_strobe, 2)
        |-> vid_a_win.x0 >= 12'h014 && vid_a_win.y0 >= 12'h001)
        else $error("reference below its minimum");
    bmp_hit_a: assert property (
        // hit and geometry register at the same edge, so the geometry is the current one
        win_hit[2] == ($past(pix_x) >= bmp_a_win.x0 && {1'b0, $past(pix_x)} < bx_end
        && $past(pix_y) >= bmp_a_win.y0 && {1'b0, $past(pix_y)} < by_end))
        else $error("bitmap window hit wrong");
endmodule : owg_regs_asserts

bind owg_regs owg_regs_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .vertical_sync_strobe, .s_axi_araddr,
    .s_axi_rdata, .s_axi_rresp, .pix_x, .pix_y, .cursor_x0, .cursor_y0, .vid_a_win,
    .vid_b_win, .bmp_a_win, .win_hit);

/* tb/owg_regs_tb.sv */
`timescale 1ns/1ps
module owg_regs_tb
    import owg_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, vertical_sync_strobe = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF, win_hit;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [11:0] pix_x = 12'h000, pix_y = 12'h000, cursor_x0, cursor_y0;
    owg_win_s    vid_a_win, vid_b_win, bmp_a_win, bmp_b_win;
    int          mismatches = 0, checks = 0;

    owg_regs u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vertical_sync_strobe,
        .pix_x, .pix_y, .vid_a_win, .vid_b_win, .bmp_a_win, .bmp_b_win, .cursor_x0,
        .cursor_y0, .win_hit);

    initial forever #50 aclk = ~aclk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    // a hung handshake ends the run instead of stalling it
    task automatic tmo(inout int n);
        n++;
        if (n > 40)
        begin
            chk("handshake", 32'h1, 32'h0);
            final_report();
        end
    endtask : tmo

    // address and data offered together, each released at the edge it is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa, pw, pb, ta, tw;
        logic [1:0] r;
        int n;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa | pw | pb)
        begin
            @(negedge aclk);
            ta = pa & s_axi_awready;
            tw = pw & s_axi_wready;
            pb = !s_axi_bvalid;
            r = s_axi_bresp;
            tmo(n);
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (!pb) s_axi_bready <= 1'b0;
            pa = pa & !ta;
            pw = pw & !tw;
        end
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic pa, pr, ta;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        pa = 1'b1;
        pr = 1'b1;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (pa | pr)
        begin
            @(negedge aclk);
            ta = pa & s_axi_arready;
            pr = !s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            tmo(n);
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (!pr) s_axi_rready <= 1'b0;
            pa = pa & !ta;
        end
        chk("rdata", ed, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : rd

    // one-cycle strobe; outputs settle one edge after it is sampled
    task automatic vsync();
        @(posedge aclk);
        vertical_sync_strobe <= 1'b1;
        @(posedge aclk);
        vertical_sync_strobe <= 1'b0;
        @(posedge aclk);
        @(negedge aclk);
    endtask : vsync

    task automatic field_readback();
        logic [31:0] m;
        for (int i = 0; i < NREG; i++)
            rd(8'(i * 4), 32'h0, RESP_OKAY);
        for (int i = 0; i < 16; i++)
        begin
            m = (i % 4 == 3) ? 32'h3FF : 32'h7FF;
            wr(8'(i * 4), m, RESP_OKAY);
            rd(8'(i * 4), m, RESP_OKAY);
        end
        // only the clamped reference is in use until the first sync
        chk("vid_b x0 before sync", 32'h014, vid_b_win.x0);
    endtask : field_readback

    task automatic shadow_ref();
        vsync();
        chk("vid_a x0", 32'h014, vid_a_win.x0);
        chk("vid_a y0", 32'h001, vid_a_win.y0);
        chk("vid_a w", 32'h7FF, vid_a_win.w);
        chk("vid_a h", 32'h7FF, vid_a_win.h);
        chk("bmp_b x0", 32'h813, bmp_b_win.x0);
        chk("vid_b x0", 32'h813, vid_b_win.x0);
        chk("vid_b y0", 32'h400, vid_b_win.y0);
        chk("bmp_b h", 32'h7FF, bmp_b_win.h);
        chk("cursor x0", 32'h813, cursor_x0);
        chk("cursor y0", 32'h400, cursor_y0);
        wr(OFF_CTRL, 32'h1, RESP_OKAY);
        wr(OFF_REF_X, 32'h5, RESP_OKAY);
        vsync();
        chk("vid_a x0 post", 32'h016, vid_a_win.x0);
    endtask : shadow_ref

    // bitmap a spans 68h..6Ah by lines 9..10; probe both sides of each edge
    task automatic window_hit();
        logic [11:0] hx [6] = '{12'h067, 12'h068, 12'h06A, 12'h06B, 12'h068, 12'h068};
        logic [11:0] hy [6] = '{12'h009, 12'h009, 12'h00A, 12'h009, 12'h00B, 12'h008};
        logic [5:0]  hv = 6'b000110;
        wr(OFF_REF_X, 32'h64, RESP_OKAY);
        wr(OFF_REF_Y, 32'h9, RESP_OKAY);
        wr(OFF_BMP_A_X, 32'h4, RESP_OKAY);
        wr(OFF_BMP_A_Y, 32'h0, RESP_OKAY);
        wr(OFF_BMP_A_W, 32'h3, RESP_OKAY);
        wr(OFF_BMP_A_H, 32'h2, RESP_OKAY);
        chk("bmp_a w mid frame", 32'h7FF, bmp_a_win.w);
        vsync();
        chk("bmp_a x0", 32'h068, bmp_a_win.x0);
        chk("bmp_a y0", 32'h009, bmp_a_win.y0);
        chk("bmp_a w", 32'h003, bmp_a_win.w);
        chk("bmp_a h", 32'h002, bmp_a_win.h);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge aclk);
            pix_x <= hx[i];
            pix_y <= hy[i];
            @(posedge aclk);
            @(negedge aclk);
            chk("bmp_a hit", {31'h0, hv[i]}, {31'h0, win_hit[2]});
        end
        rd(8'h4C, 32'h0, RESP_SLVERR);
        wr(8'h80, 32'h1, RESP_SLVERR);
        rd(8'h02, 32'h0, RESP_SLVERR);
    endtask : window_hit

    // byte strobes merge into the written copy: low byte first, then bits 10:8
    task automatic strobe_merge();
        wr(OFF_BMP_B_W, 32'h356, RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        wr(OFF_BMP_B_W, 32'h7AB, RESP_OKAY);
        rd(OFF_BMP_B_W, 32'h3AB, RESP_OKAY);
        s_axi_wstrb <= 4'h2;
        wr(OFF_BMP_B_W, 32'h500, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(OFF_BMP_B_W, 32'h5AB, RESP_OKAY);
    endtask : strobe_merge

    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        field_readback();
        shadow_ref();
        window_hit();
        strobe_merge();
        final_report();
    end
endmodule : owg_regs_tb
